// >>> hdl/fsp_pkg.sv
// Purpose: Constants and types for the flash self-programming sequencer
// Assumes: 200 MHz core clock, 32-bit AXI4-Lite register access
// Notes:   Shared by the sequencer and its bench
package fsp_pkg;

  // Register byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PTR  = 5'h04;
  localparam logic [4:0] ADDR_DATA = 5'h08;
  localparam logic [4:0] ADDR_LOCK = 5'h0c;
  localparam logic [4:0] ADDR_BUFV = 5'h10;

  // Control register bit positions
  localparam int CTRL_IE   = 7;
  localparam int CTRL_BUSY = 6;
  localparam int CTRL_CMDW = 5;

  // Command patterns in the low five control bits
  localparam logic [4:0] CMD_NONE = 5'h00;
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LSET = 5'h09;
  localparam logic [4:0] CMD_PGWR = 5'h05;
  localparam logic [4:0] CMD_PGER = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;

  // Instruction windows in cycles
  localparam logic [2:0] WIN_STORE    = 3'h4;
  localparam logic [2:0] WIN_LOAD_END = 3'h1;

  // Pointer layout
  localparam int         PAGE_LSB   = 6;
  localparam int         PAGE_W     = 7;
  localparam int         WORD_LSB   = 1;
  localparam int         WORD_W     = 5;
  localparam int         BUF_DEPTH  = 32;
  localparam logic [6:0] HALTING_CODE_SECTION_FIRST = 7'h60;

  // Fuse and lock read selectors
  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  localparam logic [7:0] LOCK_RST  = 8'hff;
  localparam int         BOOT_LSB  = 2;
  localparam int         BOOT_W    = 4;
  localparam logic [3:0] EXT_FILL  = 4'hf;

  // Flash operation codes on the status port
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_ERAS = 2'h1;
  localparam logic [1:0] OP_WRIT = 2'h2;
  localparam logic [1:0] OP_LOCK = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_NS  = 3_700_000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_RUN  = 3'b100
  } fsp_state_t;

endpackage

// >>> hdl/fsp_ctrl.sv
// Purpose: Flash self-programming sequencer with AXI4-Lite registers
// Assumes: Store/load instruction strobes are one-cycle pulses from the core
// Notes:   Operation engine survives system reset; only supply reset stops it
//
// Summary of operation
// - Erase command then store within four cycles erases the pointer's page.
// - Erase takes only the page field; other pointer bits and data ignored.
// - Halt core for halting-section targets; keep that section readable otherwise.
// - Load command then store within four cycles writes one buffer word.
// - Buffer location comes from the pointer's word-select field.
// - Buffer clears after page write, on re-enable command, on system reset.
// - EEPROM write during buffer loading discards all loaded data.
// - Write command then store programs the page from the buffer.
// - Ready interrupt stays asserted while enabled and enable bit clear.
// - Erase or write of a read-while-write page blocks that section; busy flag set.
// - Lock command then store programs boot lock bits cleared in data 5..2.
// - Lock programming leaves all flash readable.
// - Pending EEPROM write refuses every command and fuse or lock read.
// - Lock command then load within three cycles at 0x0001 returns lock byte.
// - Enable and lock-set clear after read or when the window expires.
// - Pointer 0x0000 low fuse, 0x0003 high fuse, 0x0002 extended fuse nibble.
// - Programmed bits read zero, unprogrammed bits read one.
// - A system reset does not stop a flash write in progress.
// - Only the five listed command patterns act; others do nothing.
// - Starting a buffer load clears the busy flag.
// - Page address is latched when an operation starts.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        supply_rst_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [4:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        spm_exec_i,
  input  wire logic        lpm_exec_i,
  input  wire logic        eeprom_write_pending_i,
  input  wire logic [7:0]  fuse_low_byte_i,
  input  wire logic [7:0]  fuse_high_byte_i,
  input  wire logic [3:0]  fuse_extended_byte_i,
  output logic [7:0]       lpm_data_o,
  output logic             lpm_hit_o,
  output logic             cpu_halt_o,
  output logic             rww_read_block_o,
  output logic             ready_irq_o,
  output logic [1:0]       flash_op_o,
  output logic [6:0]       flash_page_o
);

  function automatic logic legal_cmd(input logic [4:0] c);
    legal_cmd = (c == CMD_REEN) || (c == CMD_LSET) || (c == CMD_PGWR) ||
                (c == CMD_PGER) || (c == CMD_LOAD);
  endfunction

  fsp_state_t  st;
  logic [4:0]  cmd;
  logic [2:0]  win;
  logic [19:0] cnt;
  logic [7:0]  lock_bits;
  logic        irq_en;
  logic [15:0] ptr;
  logic [15:0] data_pair;
  logic [15:0] buf_mem [BUF_DEPTH];
  logic [BUF_DEPTH-1:0] buf_vld;

  logic        wr_go;
  logic        ctrl_wr;
  logic        cmd_ok;
  logic        spm_ok;
  logic        lpm_ok;
  logic        load_go;
  logic        run_done;
  logic        buf_clr;
  logic        prog_en;
  logic        irq_next;
  logic [6:0]  ptr_page;
  logic [4:0]  ptr_word;
  logic [31:0] rd_word;
  logic [7:0]  rd_byte;

  assign ptr_page = ptr[PAGE_LSB +: PAGE_W];
  assign ptr_word = ptr[WORD_LSB +: WORD_W];
  assign prog_en  = (st != ST_IDLE);
  assign irq_next = irq_en && !prog_en;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign wr_go   = s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i;
  assign ctrl_wr = wr_go && (s_axi_awaddr_i == ADDR_CTRL) && s_axi_wstrb_i[0];
  assign cmd_ok  = ctrl_wr && (st == ST_IDLE) && !eeprom_write_pending_i &&
                   legal_cmd(s_axi_wdata_i[4:0]);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else if (ce_i) begin
      if (wr_go) begin
        s_axi_awready_o <= 1'b0;
        s_axi_wready_o  <= 1'b0;
        s_axi_bvalid_o  <= 1'b1;
        s_axi_bresp_o   <= (s_axi_awaddr_i <= ADDR_BUFV) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o) begin
        if (s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end else if (s_axi_awvalid_i && s_axi_wvalid_i) begin
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Software-held registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en    <= 1'b0;
      ptr       <= 16'h0000;
      data_pair <= 16'h0000;
    end else if (ce_i && wr_go) begin
      unique case (s_axi_awaddr_i)
        ADDR_CTRL: if (s_axi_wstrb_i[0]) begin
          irq_en <= s_axi_wdata_i[CTRL_IE];
        end
        ADDR_PTR: begin
          if (s_axi_wstrb_i[0]) ptr[7:0]  <= s_axi_wdata_i[7:0];
          if (s_axi_wstrb_i[1]) ptr[15:8] <= s_axi_wdata_i[15:8];
        end
        ADDR_DATA: begin
          if (s_axi_wstrb_i[0]) data_pair[7:0]  <= s_axi_wdata_i[7:0];
          if (s_axi_wstrb_i[1]) data_pair[15:8] <= s_axi_wdata_i[15:8];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr_i)
      ADDR_CTRL: rd_word[7:0] = {irq_en, rww_read_block_o, 1'b0, cmd};
      ADDR_PTR:  rd_word[15:0] = ptr;
      ADDR_DATA: rd_word[15:0] = data_pair;
      ADDR_LOCK: rd_word[7:0] = lock_bits;
      ADDR_BUFV: rd_word[15:0] = buf_vld[ptr_word] ? buf_mem[ptr_word] : 16'hffff;
      default:   rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arready_o && s_axi_arvalid_i) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word;
        s_axi_rresp_o   <= (s_axi_araddr_i <= ADDR_BUFV) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o) begin
        if (s_axi_rready_i) begin
          s_axi_rvalid_o <= 1'b0;
        end
      end else if (s_axi_arvalid_i) begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation engine

  assign spm_ok   = (st == ST_ARM) && spm_exec_i && !eeprom_write_pending_i;
  // Load must land in the first three cycles
  assign lpm_ok   = (st == ST_ARM) && (cmd == CMD_LSET) && lpm_exec_i &&
                    !spm_exec_i && (win > WIN_LOAD_END) && !eeprom_write_pending_i;
  assign load_go  = spm_ok && (cmd == CMD_LOAD);
  assign run_done = (st == ST_RUN) && (cnt == 20'h0_0001);

  always_comb begin
    unique case (ptr)
      PTR_FUSE_LOW:  rd_byte = fuse_low_byte_i;
      PTR_LOCK:      rd_byte = lock_bits;
      PTR_FUSE_EXT:  rd_byte = {EXT_FILL, fuse_extended_byte_i};
      PTR_FUSE_HIGH: rd_byte = fuse_high_byte_i;
      default:       rd_byte = 8'hff;
    endcase
  end

  // Engine reset only by supply reset
  always_ff @(posedge core_clk_i or posedge supply_rst_i) begin
    if (supply_rst_i) begin
      st               <= ST_IDLE;
      cmd              <= CMD_NONE;
      win              <= 3'h0;
      cnt              <= 20'h0_0000;
      lock_bits        <= LOCK_RST;
      lpm_data_o       <= 8'h00;
      lpm_hit_o        <= 1'b0;
      cpu_halt_o       <= 1'b0;
      rww_read_block_o <= 1'b0;
      flash_op_o       <= OP_NONE;
      flash_page_o     <= 7'h00;
    end else if (ce_i) begin
      lpm_hit_o <= 1'b0;
      unique case (st)
        ST_IDLE: if (cmd_ok) begin
          cmd <= s_axi_wdata_i[4:0];
          win <= WIN_STORE;
          st  <= ST_ARM;
        end
        ST_ARM: if (spm_ok) begin
          if (cmd == CMD_PGER || cmd == CMD_PGWR) begin
            st           <= ST_RUN;
            cnt          <= 20'(PROG_CYC);
            flash_page_o <= ptr_page;
            flash_op_o   <= (cmd == CMD_PGER) ? OP_ERAS : OP_WRIT;
            cpu_halt_o   <= (ptr_page >= HALTING_CODE_SECTION_FIRST);
            if (ptr_page < HALTING_CODE_SECTION_FIRST) begin
              rww_read_block_o <= 1'b1;
            end
          end else if (cmd == CMD_LSET) begin
            st         <= ST_RUN;
            cnt        <= 20'(PROG_CYC);
            flash_op_o <= OP_LOCK;
            // Lock data taken at the store
            lock_bits[BOOT_LSB +: BOOT_W] <= lock_bits[BOOT_LSB +: BOOT_W] & data_pair[BOOT_LSB +: BOOT_W];
          end else begin
            rww_read_block_o <= 1'b0;
            cmd              <= CMD_NONE;
            st               <= ST_IDLE;
          end
        end else if (lpm_ok) begin
          lpm_data_o <= rd_byte;
          lpm_hit_o  <= 1'b1;
          cmd        <= CMD_NONE;
          st         <= ST_IDLE;
        end else if (win == 3'h1) begin
          cmd <= CMD_NONE;
          st  <= ST_IDLE;
        end else begin
          win <= win - 3'h1;
        end
        ST_RUN: if (run_done) begin
          cmd        <= CMD_NONE;
          cpu_halt_o <= 1'b0;
          flash_op_o <= OP_NONE;
          st         <= ST_IDLE;
        end else begin
          cnt <= cnt - 20'h0_0001;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_irq_o <= 1'b0;
    end else if (ce_i) begin
      ready_irq_o <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Temporary page buffer

  // Clear after write, on re-enable command
  assign buf_clr = (run_done && cmd == CMD_PGWR) ||
                   (cmd_ok && s_axi_wdata_i[4:0] == CMD_REEN) ||
                   (eeprom_write_pending_i && (|buf_vld));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_vld <= '0;
    end else if (ce_i) begin
      if (buf_clr) begin
        buf_vld <= '0;
      end else if (load_go) begin
        buf_vld[ptr_word] <= 1'b1;
      end
    end
  end
  // First write to a location is kept
  always_ff @(posedge core_clk_i) begin
    if (ce_i && load_go && !buf_clr && !buf_vld[ptr_word]) begin
      buf_mem[ptr_word] <= data_pair;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i || supply_rst_i);
  sequence s_armed_quiet;
    st == ST_ARM && win == 3'h1 && ce_i && !spm_exec_i && !lpm_exec_i;
  endsequence
  sequence s_run_last;
    st == ST_RUN && cnt == 20'h0_0001 && ce_i;
  endsequence
  chk_bad_pattern: assert property (
    ctrl_wr && ce_i && st == ST_IDLE && !legal_cmd(s_axi_wdata_i[4:0]) |=> st == ST_IDLE)
    else $error("illegal command pattern armed the engine");

  chk_eeprom_block: assert property (
    st == ST_IDLE && eeprom_write_pending_i |=> st == ST_IDLE)
    else $error("command accepted during EEPROM write");

  chk_window_end: assert property (
    s_armed_quiet |=> st == ST_IDLE && cmd == CMD_NONE)
    else $error("window did not expire after four cycles");

  chk_run_finish: assert property (
    s_run_last |=> st == ST_IDLE && flash_op_o == OP_NONE && !cpu_halt_o)
    else $error("operation did not end on counter expiry");

  chk_halt_target: assert property (
    cpu_halt_o |-> st == ST_RUN && flash_page_o >= HALTING_CODE_SECTION_FIRST && flash_op_o != OP_LOCK)
    else $error("core halted without halting-section target");

  chk_lock_open: assert property (
    st == ST_ARM && cmd == CMD_LSET && spm_ok && ce_i && !rww_read_block_o
    |=> (!rww_read_block_o && !cpu_halt_o) [*3])
    else $error("lock programming blocked flash");

  chk_load_busy: assert property (
    load_go && ce_i |=> !rww_read_block_o && st == ST_IDLE)
    else $error("buffer load left busy flag set");

  chk_irq_level: assert property (
    $past(ce_i) |-> ready_irq_o == $past(irq_next))
    else $error("ready interrupt does not follow enable bit");

  chk_lock_read: assert property (
    lpm_ok && ce_i && ptr == PTR_LOCK |=> lpm_hit_o && lpm_data_o == $past(lock_bits))
    else $error("lock byte not returned");

  chk_page_hold: assert property (
    st == ST_RUN && ce_i && !run_done |=> $stable(flash_page_o))
    else $error("latched page changed during operation");

endmodule

`default_nettype wire

// >>> verif/fsp_core_model.sv
// Purpose: Processor core stand-in issuing store and load strobes
// Assumes: Strobes are one-cycle pulses launched after a clock edge
// Notes:   Delay counts edges after the control write is taken
`timescale 1ns/1ps
`default_nettype none

module fsp_core_model (
  input  wire logic core_clk_i,
  output logic      spm_exec_o,
  output logic      lpm_exec_o
);
  initial begin
    spm_exec_o = 1'b0;
    lpm_exec_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Single timed strobe
  task automatic pulse(input bit store, input int delay);
    repeat (delay - 1) @(posedge core_clk_i);
    if (store) begin
      spm_exec_o <= 1'b1;
    end else begin
      lpm_exec_o <= 1'b1;
    end
    @(posedge core_clk_i);
    spm_exec_o <= 1'b0;
    lpm_exec_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> verif/tb_fsp_ctrl.sv
// Purpose: Self-checking bench for the self-programming sequencer
// Assumes: Short programming time through the cycle parameter
// Notes:   Register reads and special loads are compared from queues
`timescale 1ns/1ps
`default_nettype none

module tb_fsp_ctrl;
  import fsp_pkg::*;
  localparam int PCYC = 20;
  logic        core_clk_i = 0, rst_i = 1, sup_rst = 1, eep = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [7:0]  fl = 8'hff, fh = 8'hff, lpm_data;
  logic [3:0]  fe = 4'hf;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp, op;
  logic        awready, wready, bvalid, arready, rvalid, spm, lpm;
  logic        lpm_hit, halt, rww_blk, irq;
  logic [6:0]  page;
  logic [15:0] w;
  logic [31:0] rq[$];
  logic [7:0]  lq[$];
  logic [7:0]  bad[5] = '{8'h07, 8'h0b, 8'h13, 8'h02, 8'h1f};
  int          err_count = 0, checked = 0, hits = 0;
  integer      seed = 32'h39fa10aa;

  always #2.5 core_clk_i = ~core_clk_i;

  fsp_ctrl #(.PROG_CYC(PCYC)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .supply_rst_i(sup_rst), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .spm_exec_i(spm),
    .lpm_exec_i(lpm), .eeprom_write_pending_i(eep), .fuse_low_byte_i(fl),
    .fuse_high_byte_i(fh), .fuse_extended_byte_i(fe), .lpm_data_o(lpm_data),
    .lpm_hit_o(lpm_hit), .cpu_halt_o(halt), .rww_read_block_o(rww_blk),
    .ready_irq_o(irq), .flash_op_o(op), .flash_page_o(page)
  );

  fsp_core_model core (.core_clk_i(core_clk_i), .spm_exec_o(spm), .lpm_exec_o(lpm));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    fork
      begin
        do @(posedge core_clk_i); while (awready !== 1'b1);
        awvalid <= 0;
      end
      begin
        do @(posedge core_clk_i); while (wready !== 1'b1);
        wvalid <= 0;
      end
    join
    do @(posedge core_clk_i); while (bvalid !== 1'b1);
    wr_resp = bresp;
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    fork
      begin
        do @(posedge core_clk_i); while (arready !== 1'b1);
        arvalid <= 0;
      end
      begin
        do @(posedge core_clk_i); while (rvalid !== 1'b1);
        rd_resp = rresp;
      end
    join
  endtask

  // Control write with a strobe d edges after it is taken
  task automatic cmd(input logic [7:0] c, input bit s, input int d);
    fork
      axi_wr(ADDR_CTRL, {24'h0, c});
      begin
        do @(posedge core_clk_i); while (awready !== 1'b1);
        if (d > 0) core.pulse(s, d);
      end
    join
  endtask

  task automatic op_start;
    do @(posedge core_clk_i); while (op === OP_NONE);
    @(posedge core_clk_i);
  endtask

  task automatic op_end;
    do @(posedge core_clk_i); while (op !== OP_NONE);
    repeat (2) @(posedge core_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    if (rvalid === 1'b1 && rready === 1'b1) check(rdata, rq.size() ? rq.pop_front() : 'x);
    if (lpm_hit === 1'b1) begin
      hits++;
      check(32'(lpm_data), lq.size() ? 32'(lq.pop_front()) : 'x);
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    test_done;
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 0;
    sup_rst <= 0;
    {fh, fl, fe} <= 20'($random(seed));
    @(posedge core_clk_i);
    axi_rd(ADDR_CTRL, 0);
    axi_rd(ADDR_LOCK, 32'h0000_00ff);
    axi_rd(5'h14, 0);
    check(32'(rd_resp), 32'(RESP_SLVERR));
    axi_wr(5'h14, 0);
    check(32'(wr_resp), 32'(RESP_SLVERR));
    // Fuse and lock bytes at every window delay
    for (int i = 0; i < 4; i++) begin
      axi_wr(ADDR_PTR, 32'(i));
      lq.push_back(i == 0 ? fl : i == 1 ? LOCK_RST : i == 2 ? {EXT_FILL, fe} : fh);
      cmd(8'h09, 0, i % 3 + 1);
      repeat (3) @(posedge core_clk_i);
      check(32'(hits), 32'(i + 1));
    end
    axi_rd(ADDR_CTRL, 0);
    axi_wr(ADDR_PTR, 32'h1);
    cmd(8'h09, 0, 4);
    eep <= 1;
    cmd(8'h09, 0, 1);
    cmd(8'h03, 1, 1);
    repeat (3) @(posedge core_clk_i);
    check(32'(hits), 32'h4);
    check(32'(op), 32'(OP_NONE));
    eep <= 0;
    axi_rd(ADDR_CTRL, 0);
    foreach (bad[k]) begin
      cmd(bad[k], 1, 1);
      repeat (3) @(posedge core_clk_i);
      check(32'(op), 32'(OP_NONE));
      axi_rd(ADDR_CTRL, 0);
    end
    w = 16'($random(seed));
    axi_wr(ADDR_PTR, 32'h0000_0fca);
    axi_wr(ADDR_DATA, {16'h0, w});
    cmd(8'h01, 1, 4);
    axi_rd(ADDR_BUFV, {16'h0, w});
    axi_wr(ADDR_PTR, 32'h2);
    axi_rd(ADDR_BUFV, 32'h0000_ffff);
    eep <= 1;
    repeat (2) @(posedge core_clk_i);
    eep <= 0;
    axi_wr(ADDR_PTR, 32'h0000_0fca);
    axi_rd(ADDR_BUFV, 32'h0000_ffff);
    // Erase of a read-while-write page with the interrupt on
    axi_wr(ADDR_CTRL, 32'h0000_0080);
    repeat (3) @(posedge core_clk_i);
    check(32'(irq), 32'h1);
    axi_wr(ADDR_PTR, 32'h0000_e54d);
    axi_wr(ADDR_DATA, 32'($random(seed)));
    cmd(8'h83, 1, 2);
    op_start;
    check(32'(op), 32'(OP_ERAS));
    check(32'(page), 32'h15);
    check(32'(rww_blk), 32'h1);
    check(32'(halt), 32'h0);
    axi_wr(ADDR_PTR, 0);
    check(32'(page), 32'h15);
    check(32'(irq), 32'h0);
    axi_rd(ADDR_CTRL, 32'h0000_00c3);
    op_end;
    axi_rd(ADDR_CTRL, 32'h0000_00c0);
    check(32'(irq), 32'h1);
    axi_wr(ADDR_PTR, 32'h6);
    axi_wr(ADDR_DATA, {16'h0, w});
    cmd(8'h81, 1, 1);
    repeat (2) @(posedge core_clk_i);
    check(32'(rww_blk), 32'h0);
    axi_rd(ADDR_BUFV, {16'h0, w});
    cmd(8'h11, 1, 3);
    axi_rd(ADDR_BUFV, 32'h0000_ffff);
    // Page write to the halting section
    axi_wr(ADDR_PTR, 32'h2);
    cmd(8'h01, 1, 1);
    axi_wr(ADDR_PTR, 32'h0000_1840);
    cmd(8'h05, 1, 1);
    op_start;
    check(32'(op), 32'(OP_WRIT));
    check(32'(page), 32'h61);
    check(32'(halt), 32'h1);
    check(32'(rww_blk), 32'h0);
    op_end;
    check(32'(halt), 32'h0);
    axi_wr(ADDR_PTR, 32'h2);
    axi_rd(ADDR_BUFV, 32'h0000_ffff);
    // EEPROM idle before the control write
    axi_wr(ADDR_DATA, 32'h0000_00d7);
    axi_wr(ADDR_PTR, 32'h1);
    cmd(8'h09, 1, 3);
    op_start;
    check(32'(op), 32'(OP_LOCK));
    check(32'(rww_blk | halt), 32'h0);
    rst_i <= 1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 0;
    check(32'(op), 32'(OP_LOCK));
    op_end;
    axi_rd(ADDR_LOCK, 32'h0000_00d7);
    axi_wr(ADDR_PTR, 32'h1);
    lq.push_back(8'hd7);
    cmd(8'h09, 0, 2);
    repeat (3) @(posedge core_clk_i);
    check(32'(hits), 32'h5);
    test_done;
  end
endmodule

`default_nettype wire
